// *** fbmc_host.sv ***
// host-side controller for an asynchronous boot-block flash
`timescale 1ns/1ps
`default_nettype none
`include "fbmc_defines.svh"
// Contract
// - host reads with select, oe low, we high
// - erase and program need two writes
// - issue array read after operation completes
// - write matching read-mode command before reading
module fbmc_host
   import fbmc_pkg::*;
#(
   parameter int WAKE_CYC = `FBMC_CYC(`FBMC_T_WAKE_NS)
)
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        cmdValid,    // user request strobe
   output logic             cmdReady,    // request accepted
   input  wire fbmc_op_t    cmdOp,
   input  wire logic [17:0] cmdAddr,
   input  wire logic [15:0] cmdData,
   input  wire logic        protectBoot, // wanted write-protect level
   input  wire logic        powerDown,   // request deep power-down
   output logic             rspValid,    // answer pulse
   output logic [15:0]      rspData,
   output fbmc_src_t        readSource,  // mode the device is in now
   output logic             busyFlag,    // synchronised busy from device
   output logic             chipSel_n,
   output logic             outEn_n,
   output logic             writeEn_n,
   output logic             writeProt_n,
   output logic             reset_powerdown_n,
   output logic [17:0]      addrOut,
   output logic [15:0]      data_lines_o,
   output logic             data_lines_oe_n,
   input  wire logic [15:0] data_lines_i,
   input  wire logic        ready_busy_n
);
   localparam int RESET_CYC = `FBMC_CYC(`FBMC_T_RESET_NS);
   typedef enum logic [2:0] {FBMC_H_PDOWN, FBMC_H_WAKE, FBMC_H_IDLE, FBMC_H_CYC1,
      FBMC_H_CYC2, FBMC_H_ANSWER} fbmc_hst_t;

   fbmc_cyc_if cyc ();
   fbmc_hst_t   st_r, st_nxt;
   logic [15:0] cnt_r, cnt_nxt;      // power-down and wake timer
   fbmc_op_t    op_r, op_nxt;
   logic [17:0] ad_r, ad_nxt;
   logic [15:0] wd_r, wd_nxt;
   fbmc_src_t   src_r, src_nxt;
   logic        rst_r, rst_nxt;      // reset/power-down pin level
   logic        rspV_r, rspV_nxt;
   logic [15:0] rspD_r, rspD_nxt;
   logic        wp_r;
   logic [1:0]  rbSync_r;            // two flops on ready/busy
   logic [15:0] dqS1_r, dqS2_r;      // two flops on the data lines
   logic        cycReq, cycWr;
   logic [17:0] cycAd;
   logic [15:0] cycWd;

   fbmc_pin_engine u_engine (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .cyc       (cyc.engine),
      .dqSync    (1'b0),
      .dqIn      (dqS2_r),
      .chipSel_n (chipSel_n),
      .outEn_n   (outEn_n),
      .writeEn_n (writeEn_n),
      .addrOut   (addrOut),
      .dqOut     (data_lines_o),
      .dqOe_n    (data_lines_oe_n)
   );
   assign cyc.req = cycReq;
   assign cyc.write = cycWr;
   assign cyc.addr = cycAd;
   assign cyc.wdata = cycWd;

   // synchronise device outputs before any logic reads them
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         rbSync_r <= 2'b11;               // idle pin level, no false busy after reset
         dqS1_r <= 16'h0000;
         dqS2_r <= 16'h0000;
         wp_r <= 1'b0;
      end
      else
      begin
         rbSync_r <= {rbSync_r[0], ready_busy_n};
         dqS1_r <= data_lines_i;
         dqS2_r <= dqS1_r;
         wp_r <= protectBoot;
      end
   end
   // low ready/busy means erase or program in progress
   assign busyFlag = !rbSync_r[1];

   // sequencer next state
   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      op_nxt = op_r;
      ad_nxt = ad_r;
      wd_nxt = wd_r;
      src_nxt = src_r;
      rst_nxt = rst_r;
      rspV_nxt = 1'b0;
      rspD_nxt = rspD_r;
      cmdReady = 1'b0;
      cycReq = 1'b0;
      cycWr = 1'b1;
      cycAd = ad_r;
      cycWd = wd_r;
      unique case (st_r)
         FBMC_H_PDOWN:
         begin
            // reset low for at least the minimum time
            rst_nxt = 1'b0;
            if (cnt_r != 16'h0000)
               cnt_nxt = cnt_r - 16'h0001;
            else if (!powerDown)
            begin
               rst_nxt = 1'b1;
               cnt_nxt = 16'(WAKE_CYC);
               st_nxt = FBMC_H_WAKE;
            end
         end
         FBMC_H_WAKE:
         begin
            // device comes back in array read mode
            src_nxt = FBMC_RS_ARRAY;
            if (cnt_r == 16'h0000)
               st_nxt = FBMC_H_IDLE;
            else
               cnt_nxt = cnt_r - 16'h0001;
         end
         FBMC_H_IDLE:
         begin
            if (powerDown)
            begin
               cnt_nxt = 16'(RESET_CYC);
               st_nxt = FBMC_H_PDOWN;
            end
            else if (cmdValid)
            begin
               cmdReady = 1'b1;
               op_nxt = cmdOp;
               ad_nxt = cmdAddr;
               wd_nxt = cmdData;
               st_nxt = FBMC_H_CYC1;
            end
         end
         FBMC_H_CYC1:
         begin
            cycReq = 1'b1;
            unique case (op_r)
               // reads need no supply level the engine drives select
               FBMC_OP_READ:        cycWr = 1'b0;
               FBMC_OP_READ_ARRAY:  cycWd = 16'(`FBMC_CMD_READ_ARRAY);
               FBMC_OP_READ_ID:     cycWd = 16'(`FBMC_CMD_READ_ID);
               FBMC_OP_READ_STATUS: cycWd = 16'(`FBMC_CMD_READ_STATUS);
               FBMC_OP_ERASE:       cycWd = 16'(`FBMC_CMD_ERASE_SETUP);
               FBMC_OP_PROGRAM:     cycWd = 16'(`FBMC_CMD_PROGRAM);
               FBMC_OP_SUSPEND:     cycWd = 16'(`FBMC_CMD_SUSPEND);
               FBMC_OP_RESUME:      cycWd = 16'(`FBMC_CMD_RESUME);
            endcase
            if (cyc.done)
            begin
               // track the read source the device now uses
               if (op_r == FBMC_OP_READ_ARRAY)
                  src_nxt = FBMC_RS_ARRAY;
               if (op_r == FBMC_OP_READ_ID)
                  src_nxt = FBMC_RS_ID;
               // device answers status after setup
               // supply or protect refusals are not flagged in status; busyFlag just stays low
               if (op_r == FBMC_OP_ERASE || op_r == FBMC_OP_PROGRAM ||
                   op_r == FBMC_OP_READ_STATUS || op_r == FBMC_OP_SUSPEND)
                  src_nxt = FBMC_RS_STATUS;
               rspD_nxt = cyc.rdata;
               if (op_r == FBMC_OP_ERASE || op_r == FBMC_OP_PROGRAM)
                  st_nxt = FBMC_H_CYC2;
               else
                  st_nxt = FBMC_H_ANSWER;
            end
         end
         FBMC_H_CYC2:
         begin
            // second write: confirm erase or program data
            cycReq = 1'b1;
            cycWd = (op_r == FBMC_OP_ERASE) ? 16'(`FBMC_CMD_CONFIRM) : wd_r;
            if (cyc.done)
               st_nxt = FBMC_H_ANSWER;
         end
         FBMC_H_ANSWER:
         begin
            rspV_nxt = 1'b1;
            st_nxt = FBMC_H_IDLE;
         end
      endcase
   end

   // register sequencer state
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r <= FBMC_H_PDOWN;
         cnt_r <= 16'(RESET_CYC);
         op_r <= FBMC_OP_READ;
         ad_r <= 18'h00000;
         wd_r <= 16'h0000;
         src_r <= FBMC_RS_ARRAY;
         rst_r <= 1'b0;
         rspV_r <= 1'b0;
         rspD_r <= 16'h0000;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         op_r <= op_nxt;
         ad_r <= ad_nxt;
         wd_r <= wd_nxt;
         src_r <= src_nxt;
         rst_r <= rst_nxt;
         rspV_r <= rspV_nxt;
         rspD_r <= rspD_nxt;
      end
   end

   assign reset_powerdown_n = rst_r;
   // protect low locks boot blocks in the device
   assign writeProt_n = wp_r;
   assign rspValid = rspV_r;
   assign rspData = rspD_r;
   assign readSource = src_r;
endmodule
`default_nettype wire

// *** fbmc_defines.svh ***
// constants for the flash bus mode controller
`ifndef FBMC_DEFINES_SVH
`define FBMC_DEFINES_SVH
`define FBMC_CMD_READ_ARRAY   8'hFF
`define FBMC_CMD_READ_ID      8'h90
`define FBMC_CMD_READ_STATUS  8'h70
`define FBMC_CMD_CLEAR_STATUS 8'h50
`define FBMC_CMD_ERASE_SETUP  8'h20
`define FBMC_CMD_CONFIRM      8'hD0
`define FBMC_CMD_PROGRAM      8'h40
`define FBMC_CMD_SUSPEND      8'hB0
`define FBMC_CMD_RESUME       8'hD0
`define FBMC_T_SETUP_NS       40
`define FBMC_T_STROBE_NS      60
`define FBMC_T_ACCESS_NS      90
`define FBMC_T_RESET_NS       100
`define FBMC_T_WAKE_NS        1000
`define FBMC_SYNC_STAGES      2
`define FBMC_CLK_NS           8
`define FBMC_CYC(ns) (((ns) + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)
`define FBMC_STAT_READY_BIT   7
`endif

// *** fbmc_pkg.sv ***
// types for the flash bus mode controller
package fbmc_pkg;
   typedef enum logic [2:0]
   {
      FBMC_OP_READ,
      FBMC_OP_READ_ARRAY,
      FBMC_OP_READ_ID,
      FBMC_OP_READ_STATUS,
      FBMC_OP_ERASE,
      FBMC_OP_PROGRAM,
      FBMC_OP_SUSPEND,
      FBMC_OP_RESUME
   } fbmc_op_t;
   typedef enum logic [1:0]
   {
      FBMC_RS_ARRAY,
      FBMC_RS_ID,
      FBMC_RS_STATUS
   } fbmc_src_t;
endpackage

// *** fbmc_cyc_if.sv ***
// bus cycle request and answer between the sequencer and the pin engine
`timescale 1ns/1ps
`default_nettype none
interface fbmc_cyc_if;
   logic        req;    // one bus cycle wanted
   logic        write;  // write cycle, else read
   logic [17:0] addr;   // word address
   logic [15:0] wdata;  // write data
   logic        done;   // cycle finished pulse
   logic [15:0] rdata;  // captured read data
   modport master (output req, output write, output addr, output wdata,
                   input done, input rdata);
   modport engine (input req, input write, input addr, input wdata,
                   output done, output rdata);
endinterface
`default_nettype wire

// *** fbmc_pin_engine.sv ***
// pin engine: one asynchronous flash read or write strobe cycle
`timescale 1ns/1ps
`default_nettype none
`include "fbmc_defines.svh"
module fbmc_pin_engine
   import fbmc_pkg::*;
(
   input  wire logic    clk_sys,
   input  wire logic    nrst,
   fbmc_cyc_if.engine   cyc,
   input  wire logic    dqSync,     // unused, tied low by the host; dqIn carries the synchronised data_lines
   input  wire logic [15:0] dqIn,
   output logic         chipSel_n,
   output logic         outEn_n,
   output logic         writeEn_n,
   output logic [17:0]  addrOut,
   output logic [15:0]  dqOut,
   output logic         dqOe_n
);
   localparam int SETUP = `FBMC_CYC(`FBMC_T_SETUP_NS);
   localparam int STROBE = `FBMC_CYC(`FBMC_T_STROBE_NS);
   localparam int ACCESS = `FBMC_CYC(`FBMC_T_ACCESS_NS) + `FBMC_SYNC_STAGES; // plus sync delay
   typedef enum logic [1:0] {FBMC_PE_IDLE, FBMC_PE_SETUP, FBMC_PE_STROBE, FBMC_PE_HOLD}
      fbmc_pe_t;
   fbmc_pe_t    st_r, st_nxt;
   logic [7:0]  cnt_r, cnt_nxt;
   logic        wr_r, wr_nxt;
   logic [15:0] rd_r, rd_nxt;
   logic [17:0] ad_r, ad_nxt;
   logic [15:0] wd_r, wd_nxt;
   logic        selN_r, selN_nxt;     // select pin, from a flop so it cannot glitch
   logic        oeN_r, oeN_nxt;       // output enable pin
   logic        weN_r, weN_nxt;       // write strobe pin, a glitch here would write
   logic        driveN_r, driveN_nxt; // our data driver enable

   // next state of one strobe cycle
   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      ad_nxt = ad_r;
      wd_nxt = wd_r;
      cyc.done = 1'b0;
      unique case (st_r)
         FBMC_PE_IDLE:
         begin
            if (cyc.req)
            begin
               // address and data held by us for the whole cycle
               ad_nxt = cyc.addr;
               wd_nxt = cyc.wdata;
               wr_nxt = cyc.write;
               cnt_nxt = 8'(SETUP);
               st_nxt = FBMC_PE_SETUP;
            end
         end
         FBMC_PE_SETUP:
         begin
            if (cnt_r == 8'h00)
            begin
               cnt_nxt = wr_r ? 8'(STROBE) : 8'(ACCESS);
               st_nxt = FBMC_PE_STROBE;
            end
            else
               cnt_nxt = cnt_r - 8'h01;
         end
         FBMC_PE_STROBE:
         begin
            if (cnt_r == 8'h00)
            begin
               // device latches on the write strobe rising edge
               if (!wr_r)
                  rd_nxt = dqIn;
               cnt_nxt = 8'(SETUP);
               st_nxt = FBMC_PE_HOLD;
            end
            else
               cnt_nxt = cnt_r - 8'h01;
         end
         FBMC_PE_HOLD:
         begin
            // recovery so the device floats before the next cycle
            if (cnt_r == 8'h00)
            begin
               cyc.done = 1'b1;
               st_nxt = FBMC_PE_IDLE;
            end
            else
               cnt_nxt = cnt_r - 8'h01;
         end
      endcase
      // strobes decoded from the next state, so pins leave flops glitch free
      selN_nxt = (st_nxt == FBMC_PE_IDLE);
      oeN_nxt = !(st_nxt == FBMC_PE_STROBE && !wr_nxt);
      weN_nxt = !(st_nxt == FBMC_PE_STROBE && wr_nxt);
      driveN_nxt = !(wr_nxt && st_nxt != FBMC_PE_IDLE);
   end

   // register the cycle state
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r <= FBMC_PE_IDLE;
         cnt_r <= 8'h00;
         wr_r <= 1'b0;
         rd_r <= 16'h0000;
         ad_r <= 18'h00000;
         wd_r <= 16'h0000;
         selN_r <= 1'b1;
         oeN_r <= 1'b1;
         weN_r <= 1'b1;
         driveN_r <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         ad_r <= ad_nxt;
         wd_r <= wd_nxt;
         selN_r <= selN_nxt;
         oeN_r <= oeN_nxt;
         weN_r <= weN_nxt;
         driveN_r <= driveN_nxt;
      end
   end

   // read: select and output enable low, write strobe high
   assign chipSel_n = selN_r;
   assign outEn_n = oeN_r;
   assign writeEn_n = weN_r;
   // drive data only around a write, never with output enable low
   assign dqOe_n = driveN_r;
   assign addrOut = ad_r;
   assign dqOut = wd_r;
   assign cyc.rdata = rd_r;
   logic unusedSync;
   assign unusedSync = dqSync;
endmodule
`default_nettype wire

// *** fbmc_flash_model.sv ***
// behavioural model of the boot-block flash device
`timescale 1ns/1ps
`default_nettype none
module fbmc_flash_model
#(
   parameter logic [15:0] ID_CODE = 16'h00A5, // arbitrary identifier value
   parameter int          OP_CYC  = 40        // internal operation length
)
(
   input  wire logic        chipSel_n,
   input  wire logic        outEn_n,
   input  wire logic        writeEn_n,
   input  wire logic        writeProt_n,
   input  wire logic        reset_powerdown_n,
   input  wire logic        vppOk,     // program supply above lockout
   input  wire logic        vccOk,     // core supply above lockout
   input  wire logic [17:0] addrIn,
   input  wire logic [15:0] dqIn,
   output logic      [15:0] dqOut,
   output logic             ready_busy_n
);
   logic [15:0] mem [0:262143];      // array, starts erased
   int          mode   = 0;          // 0 array, 1 id, 2 status
   logic [7:0]  pend   = 8'h00;      // setup write awaiting its partner
   logic        busy   = 1'b0;
   logic        susp   = 1'b0;
   logic        opErase;
   int          left;
   logic [17:0] opAddr;
   logic [15:0] opData;
   logic [15:0] last   = 16'h0000;   // last driven word, inverted when floating
   logic [15:0] rd;
   wire         drv    = !chipSel_n && !outEn_n && reset_powerdown_n;
   initial
      for (int k = 0; k < 262144; k++)
         mem[k] = 16'hFFFF;
   // write latched at strobe rising edge, refused under lockout
   always @(posedge writeEn_n)
      if (!chipSel_n && reset_powerdown_n && vccOk)
      begin
         if (pend != 8'h00)
         begin
            // second write; low supply or locked boot block refuses
            if (vppOk && (writeProt_n || addrIn >= 18'h02000) &&
                (pend == 8'h40 || dqIn[7:0] == 8'hD0))
            begin
               busy = 1'b1;
               left = OP_CYC;
               opAddr = addrIn;
               opData = dqIn;
               opErase = (pend == 8'h20);
            end
            pend = 8'h00;
         end
         else
            case (dqIn[7:0])
               8'hFF: mode = 0;
               8'h90: mode = 1;
               8'h70: mode = 2;
               8'h20, 8'h40:
               begin
                  pend = dqIn[7:0];
                  mode = 2;
               end
               8'hB0: if (busy) susp = 1'b1;
               8'hD0: susp = 1'b0;
               default: ;
            endcase
      end
   // self-timed operation, deselect does not stop it
   always #8
      if (busy && !susp)
      begin
         if (left > 0)
            left--;
         else
         begin
            if (opErase)
               for (int k = 0; k < 4096; k++)
                  mem[{opAddr[17:12], 12'(k)}] = 16'hFFFF;
            else
               mem[opAddr] = mem[opAddr] & opData;
            busy = 1'b0;
         end
      end
   // power-down aborts and returns to array reads
   always @(negedge reset_powerdown_n)
   begin
      busy = 1'b0;
      susp = 1'b0;
      pend = 8'h00;
      mode = 0;
   end
   // read source mux, reads ignore supply level
   assign rd = mode == 0 ? mem[addrIn] : mode == 1 ? ID_CODE : {8'h00, !busy || susp, 7'h00};
   always @(drv or rd)
      if (drv)
         last = rd;
   assign dqOut = drv ? rd : ~last; // released bus floats
   assign ready_busy_n = !(busy && !susp);
endmodule
`default_nettype wire

// *** fbmc_host_props.sv ***
// assertions on the host controller pins
`timescale 1ns/1ps
`default_nettype none
module fbmc_host_props
   import fbmc_pkg::*;
#(
   parameter int WAKE_CYC = 4
)
(
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic        cmdValid,
   input wire logic        cmdReady,
   input wire logic        protectBoot,
   input wire logic        powerDown,
   input wire logic        busyFlag,
   input wire logic        chipSel_n,
   input wire logic        outEn_n,
   input wire logic        writeEn_n,
   input wire logic        writeProt_n,
   input wire logic        reset_powerdown_n,
   input wire logic [17:0] addrOut,
   input wire logic [15:0] data_lines_o,
   input wire logic        data_lines_oe_n,
   input wire logic        ready_busy_n
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   rd_strobe_ok_a: assert property (
      !outEn_n |-> !chipSel_n && writeEn_n && reset_powerdown_n) else $error("bad read strobe");
   no_contention_a: assert property (
      !outEn_n |-> data_lines_oe_n) else $error("host drives during read");
   standby_quiet_a: assert property (
      chipSel_n |-> outEn_n && writeEn_n) else $error("strobe while deselected");
   wr_drive_a: assert property (
      !writeEn_n |-> !chipSel_n && outEn_n && !data_lines_oe_n) else $error("bad write cycle");
   wr_stable_a: assert property (
      $rose(writeEn_n) |-> $stable(addrOut) && $stable(data_lines_o)) else $error("moved at latch");
   pd_quiet_a: assert property (
      !reset_powerdown_n |-> chipSel_n && writeEn_n) else $error("access in power-down");
   pd_width_a: assert property (
      $rose(reset_powerdown_n) |-> !$past(reset_powerdown_n, 13)) else $error("reset pulse short");
   wp_follow_a: assert property (
      $past(nrst) |-> writeProt_n == $past(protectBoot)) else $error("protect not followed");
   busy_sync_a: assert property (
      $past(nrst, 2) && $past(nrst) |-> busyFlag == !$past(ready_busy_n, 2))
      else $error("busy flag wrong");
   take_idle_a: assert property (
      cmdReady |-> cmdValid && !powerDown && reset_powerdown_n && chipSel_n)
      else $error("request taken out of idle");
   cover property (!outEn_n);
   cover property ($rose(writeEn_n));
   cover property ($rose(reset_powerdown_n));
endmodule
bind fbmc_host fbmc_host_props #(.WAKE_CYC(WAKE_CYC)) i_props (
   .clk_sys(clk_sys), .nrst(nrst), .cmdValid(cmdValid), .cmdReady(cmdReady),
   .protectBoot(protectBoot), .powerDown(powerDown), .busyFlag(busyFlag),
   .chipSel_n(chipSel_n), .outEn_n(outEn_n), .writeEn_n(writeEn_n), .writeProt_n(writeProt_n),
   .reset_powerdown_n(reset_powerdown_n), .addrOut(addrOut), .data_lines_o(data_lines_o),
   .data_lines_oe_n(data_lines_oe_n), .ready_busy_n(ready_busy_n));
`default_nettype wire

// *** flash_bus_mode_control_bench.sv ***
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_bus_mode_control_bench
   import fbmc_pkg::*;
;
   localparam logic [15:0] ID = 16'h00A5; // arbitrary identifier value
   logic clk_sys = 0, nrst = 0, cmdValid = 0, protectBoot = 1, powerDown = 0, vppOk = 1, vccOk = 1;
   fbmc_op_t    cmdOp = FBMC_OP_READ;
   logic [17:0] cmdAddr = 18'h00000, addrOut;
   logic [15:0] cmdData = 16'h0000, got, rspData, data_lines_o, fOut, dqWire;
   logic cmdReady, rspValid, busyFlag, chipSel_n, outEn_n, writeEn_n, writeProt_n;
   logic reset_powerdown_n, data_lines_oe_n, ready_busy_n;
   fbmc_src_t   readSource;
   int          n_mismatch = 0, comparisons = 0, cyc = 0;
   logic [15:0] exp [int];  // expected array contents, absent means erased
   int          progQ [$];  // programmed addresses
   assign dqWire = !data_lines_oe_n ? data_lines_o : fOut; // shared data wire
   fbmc_host #(.WAKE_CYC(4)) i_dut (
      .clk_sys(clk_sys), .nrst(nrst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
      .cmdAddr(cmdAddr), .cmdData(cmdData), .protectBoot(protectBoot), .powerDown(powerDown),
      .rspValid(rspValid), .rspData(rspData), .readSource(readSource), .busyFlag(busyFlag),
      .chipSel_n(chipSel_n), .outEn_n(outEn_n), .writeEn_n(writeEn_n), .writeProt_n(writeProt_n),
      .reset_powerdown_n(reset_powerdown_n), .addrOut(addrOut), .data_lines_o(data_lines_o),
      .data_lines_oe_n(data_lines_oe_n), .data_lines_i(dqWire), .ready_busy_n(ready_busy_n));
   fbmc_flash_model #(.ID_CODE(ID), .OP_CYC(60)) i_flash (
      .chipSel_n(chipSel_n), .outEn_n(outEn_n), .writeEn_n(writeEn_n), .writeProt_n(writeProt_n),
      .reset_powerdown_n(reset_powerdown_n), .vppOk(vppOk), .vccOk(vccOk), .addrIn(addrOut),
      .dqIn(dqWire), .dqOut(fOut), .ready_busy_n(ready_busy_n));
   always #4 clk_sys = ~clk_sys;
   // hang guard
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chkData(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %0t data %h expected %h", $time, g, e);
      end
   endtask
   task automatic chkState(input logic [1:0] g, input logic [1:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %0t state %b expected %b", $time, g, e);
      end
   endtask
   function automatic logic [15:0] expRd(input int a);
      return exp.exists(a) ? exp[a] : 16'hFFFF;
   endfunction
   // one command: hold the request until taken, then wait for its answer
   task automatic run(input fbmc_op_t op, input logic [17:0] a, input logic [15:0] d);
      int n;
      cmdValid <= 1'b1;
      cmdOp <= op;
      cmdAddr <= a;
      cmdData <= d;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (cmdReady !== 1'b1 && n < 400);
      cmdValid <= 1'b0;
      do
         @(posedge clk_sys);
      while (rspValid !== 1'b1);
      got = rspData;
   endtask
   task automatic readChk(input logic [17:0] a);
      run(FBMC_OP_READ, a, 16'h0000);
      chkData(got, expRd(a));
   endtask
   // poll status until ready, then back to array reads
   task automatic waitDone();
      int n;
      run(FBMC_OP_READ_STATUS, 18'h00000, 16'h0000);
      n = 0;
      do
      begin
         run(FBMC_OP_READ, 18'h00000, 16'h0000);
         n++;
      end
      while (got[7] !== 1'b1 && n < 50);
      chkState({1'b0, got[7]}, 2'b01);
      run(FBMC_OP_READ_ARRAY, 18'h00000, 16'h0000);
   endtask
   task automatic prog(input logic [17:0] a, input logic [15:0] d, input logic ok);
      run(FBMC_OP_PROGRAM, a, d);
      repeat (4) @(posedge clk_sys);
      chkState({1'b0, busyFlag}, {1'b0, ok});
      if (ok)
      begin
         exp[a] = expRd(a) & d;
         progQ.push_back(a);
      end
      waitDone();
   endtask
   initial
   begin
      logic [17:0] a;
      void'($urandom(32'hFE7E));
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      readChk(18'h12345);
      chkState(readSource, FBMC_RS_ARRAY);
      run(FBMC_OP_READ_ID, 18'h00000, 16'h0000);
      chkState(readSource, FBMC_RS_ID);
      run(FBMC_OP_READ, 18'h00000, 16'h0000);
      chkData(got, ID);
      run(FBMC_OP_READ_STATUS, 18'h00000, 16'h0000);
      chkState(readSource, FBMC_RS_STATUS);
      run(FBMC_OP_READ, 18'h00000, 16'h0000);
      chkData(got, 16'h0080);
      run(FBMC_OP_READ_ARRAY, 18'h00000, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         a = 18'h02000 + 18'($urandom_range(32'h3DFFF));
         prog(a, 16'($urandom), 1'b1);
         readChk(a);
      end
      // lockouts: reads still work while refused
      vppOk <= 1'b0;
      prog(progQ[0], 16'h0000, 1'b0);
      readChk(progQ[0]);
      vppOk <= 1'b1;
      vccOk <= 1'b0;
      prog(progQ[0], 16'h0000, 1'b0);
      readChk(progQ[0]);
      vccOk <= 1'b1;
      protectBoot <= 1'b0;
      prog(18'h00010, 16'h0F0F, 1'b0);
      readChk(18'h00010);
      protectBoot <= 1'b1;
      prog(18'h00010, 16'h0F0F, 1'b1);
      readChk(18'h00010);
      // erase, suspended for a read elsewhere
      a = progQ[0];
      run(FBMC_OP_ERASE, a, 16'h0000);
      run(FBMC_OP_SUSPEND, a, 16'h0000);
      repeat (4) @(posedge clk_sys);
      chkState({1'b0, busyFlag}, 2'b00);
      run(FBMC_OP_READ_ARRAY, 18'h00000, 16'h0000);
      readChk(18'h00010);
      run(FBMC_OP_RESUME, a, 16'h0000);
      foreach (progQ[k])
         if (progQ[k][17:12] == a[17:12])
            exp.delete(progQ[k]);
      waitDone();
      readChk(a);
      // program suspended for a read elsewhere, resumed, then cut by power-down
      run(FBMC_OP_PROGRAM, 18'h05555, 16'h0000);
      run(FBMC_OP_SUSPEND, 18'h05555, 16'h0000);
      repeat (4) @(posedge clk_sys);
      chkState({1'b0, busyFlag}, 2'b00);
      run(FBMC_OP_READ_ARRAY, 18'h00000, 16'h0000);
      readChk(18'h00010);
      run(FBMC_OP_RESUME, 18'h05555, 16'h0000);
      chkState({1'b0, busyFlag}, 2'b01);
      powerDown <= 1'b1;
      repeat (30) @(posedge clk_sys);
      powerDown <= 1'b0;
      readChk(18'h05555);
      chkState(readSource, FBMC_RS_ARRAY);
      chkState({1'b0, busyFlag}, 2'b00);
      complete_run();
   end
endmodule
`default_nettype wire
